// >>> rtl/twim_core.sv
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - watchdog control bit 7 stops watchdog at 0, runs it at 1
// - bit 6 selects external interrupt zero on pin2; 0 masks the path
// - port 5 read returns pin levels even in interrupt mode
// - bit 5 selects external interrupt one on pin3; 0 masks the path
// - watchdog prescale enable 0 gives 1:1, 1 uses select bits
// - watchdog select codes give ratio 1:2 up to 1:256, doubling
// - bit 0 lets low voltage flag raise interrupt
// - interrupt mask bits enable pwm c,b,a, adc, ext1, ext0, port, timer
// - global enable set by enable, cleared by disable instruction
// - two independent 8-bit prescalers for timer and watchdog
// - writing the timer clears the timer prescaler
// - watchdog clear or sleep clears watchdog and its prescaler
// - internal source without prescale increments timer each instruction cycle
// - instruction clock is oscillator divided by two or four
// - external source counts on chosen pin edge; levels last over one cycle
// - internal timer halts in sleep unless adc wake during conversion
// - watchdog runs during sleep and its time-out resets device
// - unprescaled watchdog period is about 18 ms
// - port 6 change wakes only if wake enable set before sleep
// - port change with mask set vectors if global enable, else continues
module twim_core
   import twim_pkg::*;
#(
   parameter int WDOG_CYCLES = TWIM_WDOG_CYCLES
)
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hsel,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  port5_pins,
   input  wire logic [7:0]  port6_pins,
   input  wire logic        timer_pin,
   input  wire logic [2:0]  pwm_flags,
   input  wire logic        adc_done_flag,
   input  wire logic        adc_busy,
   input  wire logic        low_voltage_flag,
   output logic             irq_request,
   output logic             vector_taken,
   output logic             wake_up,
   output logic             sleeping,
   output logic             watchdog_reset
);
   initial
   begin
      if (WDOG_CYCLES < 2) $error("twim_core: WDOG_CYCLES too small");
   end

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [7:0] p5_s1, p5_s2, p5_s3;
   logic [7:0] p6_s1, p6_s2, p6_s3;
   logic [2:0] tp_s;
   logic       tp_level;
   logic [7:0] p6_level;

   // three stages; a timer pin or port 6 change counts once stages two and three agree
   always_ff @(posedge clock)
   begin
      p5_s1 <= port5_pins;
      p5_s2 <= p5_s1;
      p5_s3 <= p5_s2;
      p6_s1 <= port6_pins;
      p6_s2 <= p6_s1;
      p6_s3 <= p6_s2;
      tp_s  <= {tp_s[1:0], timer_pin};
   end

   logic tp_change;
   assign tp_change = (tp_s[1] == tp_s[2]) && (tp_s[2] != tp_level);

   // filtered levels advance only on agreement
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         tp_level <= 1'b0;
         p6_level <= 8'h00;
      end
      else
      begin
         if (tp_change)
            tp_level <= tp_s[2];
         for (int i = 0; i < 8; i++)
            if (p6_s2[i] == p6_s3[i])
               p6_level[i] <= p6_s3[i];
      end
   end

   // ************************************************************
   // registers and bus decode
   // ************************************************************
   logic [7:0] watchdog_control;
   logic [7:0] interrupt_mask;
   logic [5:0] timer_control;
   logic [7:0] timer_count;
   logic [2:0] wake_control;
   logic       global_irq_enable;
   logic       timer_overflow_flag;
   logic       port_change_flag;
   logic       ext0_flag;
   logic       ext1_flag;
   logic       sleep_state;
   logic       wake_armed;

   logic       wr_pending;
   logic [7:0] wr_addr;
   logic       addr_phase;
   logic       wr_ctrl, wr_mask, wr_tctl, wr_timer, wr_cmd, wr_wake;
   logic [7:0] cmd;
   logic       cmd_wdclr, cmd_sleep, cmd_eni, cmd_disable_interrupts_instruction, cmd_clr_tof, cmd_wake;

   assign addr_phase  = hsel && hready && htrans[1];
   assign wr_ctrl     = wr_pending && (wr_addr == TWIM_ADDR_WDOG_CTRL);
   assign wr_mask     = wr_pending && (wr_addr == TWIM_ADDR_IRQ_MASK);
   assign wr_tctl     = wr_pending && (wr_addr == TWIM_ADDR_TIMER_CTRL);
   assign wr_timer    = wr_pending && (wr_addr == TWIM_ADDR_TIMER);
   assign wr_cmd      = wr_pending && (wr_addr == TWIM_ADDR_COMMAND);
   assign wr_wake     = wr_pending && (wr_addr == TWIM_ADDR_WAKE_CTRL);
   assign cmd         = wr_cmd ? hwdata[7:0] : 8'h00;
   assign cmd_wdclr   = cmd[TWIM_CMD_WDOG_CLEAR];
   assign cmd_sleep   = cmd[TWIM_CMD_SLEEP];
   assign cmd_eni     = cmd[TWIM_CMD_ENABLE_IRQ];
   assign cmd_disable_interrupts_instruction    = cmd[TWIM_CMD_DISABLE_IRQ];
   assign cmd_clr_tof = cmd[TWIM_CMD_CLEAR_TOF];
   assign cmd_wake    = cmd[TWIM_CMD_WAKE];

   // write data arrives one cycle after the address phase
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         wr_pending <= 1'b0;
         wr_addr    <= 8'h00;
      end
      else
      begin
         wr_pending <= addr_phase && hwrite;
         wr_addr    <= haddr[7:0];
      end
   end

   // read mux; port 5 level is visible whatever the pin mode
   logic [31:0] next_rdata;
   logic [7:0]  status_byte;
   assign status_byte = {1'b0, sleep_state, global_irq_enable, port_change_flag,
                         ext1_flag, ext0_flag, low_voltage_flag, timer_overflow_flag};
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      unique case (haddr[7:0])
         TWIM_ADDR_WDOG_CTRL:  next_rdata = {24'h000000, watchdog_control};
         TWIM_ADDR_IRQ_MASK:   next_rdata = {24'h000000, interrupt_mask};
         TWIM_ADDR_TIMER_CTRL: next_rdata = {26'h0000000, timer_control};
         TWIM_ADDR_TIMER:      next_rdata = {24'h000000, timer_count};
         TWIM_ADDR_STATUS:     next_rdata = {16'h0000, p5_s3, status_byte};
         TWIM_ADDR_WAKE_CTRL:  next_rdata = {29'h00000000, wake_control};
         default:              next_rdata = 32'h0000_0000;
      endcase
   end

   // zero wait states, always okay
   always_ff @(posedge clock)
   begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (addr_phase && !hwrite)
         hrdata <= next_rdata;
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // control registers; bit 7 enables watchdog at any time
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         watchdog_control <= TWIM_WDOG_CTRL_RESET;
         interrupt_mask   <= TWIM_IRQ_MASK_RESET;
         timer_control    <= TWIM_TIMER_CTRL_RESET[5:0];
         wake_control     <= 3'h0;
      end
      else
      begin
         if (wr_ctrl)
            watchdog_control <= hwdata[7:0];
         if (wr_mask)
            interrupt_mask <= hwdata[7:0];
         if (wr_tctl)
            timer_control <= hwdata[5:0];
         if (wr_wake)
            wake_control <= hwdata[2:0];
      end
   end

   // ************************************************************
   // instruction clock and prescalers
   // ************************************************************
   logic [1:0] osc_div;
   logic       instr_tick;
   logic       clk_by_four;
   assign clk_by_four = wake_control[TWIM_WK_CLKSEL_BIT];
   // one enable per instruction cycle: fosc/2 or fosc/4
   always_ff @(posedge clock)
   begin
      if (rst)
         osc_div <= 2'h0;
      else
         osc_div <= 2'(osc_div + 1'b1);
   end
   assign instr_tick = clk_by_four ? (osc_div == 2'h3) : osc_div[0];

   logic tc_edge_hit;
   logic tc_src_tick;
   logic tc_halted;
   logic tc_tick;
   logic adc_keep;
   logic wd_tick;
   logic wd_clear;

   // external edge: rising when edge bit 0, falling when 1
   assign tc_edge_hit = tp_change && (tp_s[2] != timer_control[TWIM_TC_EDGE_BIT]);
   assign tc_halted   = sleep_state && !adc_keep;
   assign tc_src_tick = timer_control[TWIM_TC_SOURCE_BIT] ? tc_edge_hit
                                                          : (instr_tick && !tc_halted);
   assign wd_clear    = cmd_wdclr || cmd_sleep;

   // separate counters so the two rates never interfere
   twim_prescaler #(.WIDTH(8)) timer_psc
   (
      .clock    (clock),
      .rst      (rst),
      .clear    (wr_timer),
      .tick     (tc_src_tick),
      .enable   (timer_control[TWIM_TC_PSC_EN_BIT]),
      .select   (timer_control[TWIM_TC_PSC_SEL_LSB +: 3]),
      .out_tick (tc_tick)
   );

   twim_prescaler #(.WIDTH(8)) wdog_psc
   (
      .clock    (clock),
      .rst      (rst),
      .clear    (wd_clear),
      .tick     (watchdog_control[TWIM_WD_ENABLE_BIT]),
      .enable   (watchdog_control[TWIM_WD_PSC_EN_BIT]),
      .select   (watchdog_control[TWIM_WD_PSC_SEL_LSB +: 3]),
      .out_tick (wd_tick)
   );

   // ************************************************************
   // timer/counter
   // ************************************************************
   logic timer_wrap;
   assign timer_wrap = tc_tick && (timer_count == 8'hFF);
   // bus write wins over an increment in the same cycle
   always_ff @(posedge clock)
   begin
      if (rst)
         timer_count <= 8'h00;
      else if (wr_timer)
         timer_count <= hwdata[7:0];
      else if (tc_tick)
         timer_count <= 8'(timer_count + 1'b1);
   end

   // ************************************************************
   // watchdog; the main clock stands in for its own oscillator
   // ************************************************************
   logic [31:0] wd_count;
   logic        wd_timeout;
   assign wd_timeout = wd_tick && (wd_count == 32'(WDOG_CYCLES - 1));
   always_ff @(posedge clock)
   begin
      if (rst || wd_clear || !watchdog_control[TWIM_WD_ENABLE_BIT])
         wd_count <= 32'h0000_0000;
      else if (wd_timeout)
         wd_count <= 32'h0000_0000;
      else if (wd_tick)
         wd_count <= 32'(wd_count + 1'b1);
   end

   // time-out pulses reset; counts also while sleeping
   always_ff @(posedge clock)
   begin
      if (rst)
         watchdog_reset <= 1'b0;
      else
         watchdog_reset <= wd_timeout;
   end

   // ************************************************************
   // interrupt flags, sleep and wake
   // ************************************************************
   logic [7:0] p6_seen;
   logic       p6_change;
   logic       ext0_fall, ext1_fall;
   logic [7:0] pending;
   logic       any_irq;
   logic       port_wake;
   assign p6_change = (p6_level != p6_seen);
   assign ext0_fall = watchdog_control[TWIM_WD_EXT0_BIT] && p5_s3[2] && !p5_s2[2];
   assign ext1_fall = watchdog_control[TWIM_WD_EXT1_BIT] && p5_s3[3] && !p5_s2[3];
   assign pending   = {pwm_flags, adc_done_flag, ext1_flag, ext0_flag,
                       port_change_flag, timer_overflow_flag} & interrupt_mask;
   assign any_irq   = (|pending) ||
                      (low_voltage_flag && watchdog_control[TWIM_WD_LVD_IE_BIT]);
   assign port_wake = sleep_state && wake_armed && p6_change;

   // set beats clear for every hardware flag
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timer_overflow_flag <= 1'b0;
         port_change_flag    <= 1'b0;
         ext0_flag           <= 1'b0;
         ext1_flag           <= 1'b0;
         p6_seen             <= 8'h00;
      end
      else
      begin
         p6_seen <= p6_level;
         if (timer_wrap)
            timer_overflow_flag <= 1'b1;
         else if (cmd_clr_tof || wr_timer)
            timer_overflow_flag <= 1'b0;
         if (p6_change)
            port_change_flag <= 1'b1;
         else if (cmd_clr_tof)
            port_change_flag <= 1'b0;
         if (ext0_fall)
            ext0_flag <= 1'b1;
         else if (cmd_clr_tof)
            ext0_flag <= 1'b0;
         if (ext1_fall)
            ext1_flag <= 1'b1;
         else if (cmd_clr_tof)
            ext1_flag <= 1'b0;
      end
   end

   // global enable; the enable instruction wins if both are written
   always_ff @(posedge clock)
   begin
      if (rst)
         global_irq_enable <= 1'b0;
      else if (cmd_eni)
         global_irq_enable <= 1'b1;
      else if (cmd_disable_interrupts_instruction)
         global_irq_enable <= 1'b0;
   end

   // wake enable is captured at sleep entry, so later writes do not arm it
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sleep_state <= 1'b0;
         wake_armed  <= 1'b0;
         adc_keep    <= 1'b0;
      end
      else if (cmd_sleep)
      begin
         sleep_state <= 1'b1;
         wake_armed  <= wake_control[TWIM_WK_PORT_BIT];
         adc_keep    <= adc_busy && wake_control[TWIM_WK_ADC_BIT];
      end
      else if (port_wake || cmd_wake || wd_timeout)
      begin
         sleep_state <= 1'b0;
         wake_armed  <= 1'b0;
         adc_keep    <= 1'b0;
      end
   end

   // outputs registered; vector only with global enable, else continue
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         irq_request  <= 1'b0;
         vector_taken <= 1'b0;
         wake_up      <= 1'b0;
         sleeping     <= 1'b0;
      end
      else
      begin
         irq_request  <= any_irq && global_irq_enable;
         vector_taken <= port_change_flag && interrupt_mask[1] && global_irq_enable;
         wake_up      <= port_wake;
         sleeping     <= sleep_state;
      end
   end
endmodule // twim_core

// >>> rtl/twim_pkg.sv
package twim_pkg;
   // ************************************************************
   // register map (byte addresses, one word each)
   // ************************************************************
   localparam logic [7:0] TWIM_ADDR_WDOG_CTRL  = 8'h00;
   localparam logic [7:0] TWIM_ADDR_IRQ_MASK   = 8'h04;
   localparam logic [7:0] TWIM_ADDR_TIMER_CTRL = 8'h08;
   localparam logic [7:0] TWIM_ADDR_TIMER      = 8'h0C;
   localparam logic [7:0] TWIM_ADDR_COMMAND    = 8'h10;
   localparam logic [7:0] TWIM_ADDR_STATUS     = 8'h14;
   localparam logic [7:0] TWIM_ADDR_WAKE_CTRL  = 8'h18;

   // ************************************************************
   // watchdog control field positions
   // ************************************************************
   localparam int TWIM_WD_ENABLE_BIT   = 7;
   localparam int TWIM_WD_EXT0_BIT     = 6;
   localparam int TWIM_WD_EXT1_BIT     = 5;
   localparam int TWIM_WD_PSC_EN_BIT   = 4;
   localparam int TWIM_WD_PSC_SEL_LSB  = 1;
   localparam int TWIM_WD_LVD_IE_BIT   = 0;

   // timer control: source, edge, prescale enable, select[2:0]
   localparam int TWIM_TC_SOURCE_BIT   = 5;
   localparam int TWIM_TC_EDGE_BIT     = 4;
   localparam int TWIM_TC_PSC_EN_BIT   = 3;
   localparam int TWIM_TC_PSC_SEL_LSB  = 0;

   // command bits (write one to execute)
   localparam int TWIM_CMD_WDOG_CLEAR  = 0;
   localparam int TWIM_CMD_SLEEP       = 1;
   localparam int TWIM_CMD_ENABLE_IRQ  = 2;
   localparam int TWIM_CMD_DISABLE_IRQ = 3;
   localparam int TWIM_CMD_CLEAR_TOF   = 4;
   localparam int TWIM_CMD_WAKE        = 5;

   // wake control bits
   localparam int TWIM_WK_PORT_BIT     = 0;
   localparam int TWIM_WK_ADC_BIT      = 1;
   localparam int TWIM_WK_CLKSEL_BIT   = 2;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] TWIM_WDOG_CTRL_RESET  = 8'h00;
   localparam logic [7:0] TWIM_IRQ_MASK_RESET   = 8'h00;
   localparam logic [7:0] TWIM_TIMER_CTRL_RESET = 8'h00;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int TWIM_CLOCK_MHZ       = 250;
   localparam int TWIM_WDOG_PERIOD_US  = 18000;
   // watchdog time-out, unprescaled, in clock cycles
   localparam int TWIM_WDOG_CYCLES     = TWIM_WDOG_PERIOD_US * TWIM_CLOCK_MHZ;
   localparam int TWIM_SYNC_STAGES     = 3;
endpackage

// >>> rtl/twim_prescaler.sv
`timescale 1ns/1ps
// 8-bit prescaler: ratio 2^(sel+1) when enabled, 1:1 when not
module twim_prescaler
   import twim_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       tick,
   input  wire logic       enable,
   input  wire logic [2:0] select,
   output logic            out_tick
);
   initial
   begin
      if (WIDTH != 8) $error("twim_prescaler supports WIDTH 8 only");
   end

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic [WIDTH-1:0] top;
   logic             wrap;

   // terminal count is ratio minus one
   assign top        = WIDTH'((9'h002 << select) - 9'h001);
   assign wrap       = tick && (count == top);
   assign next_count = wrap ? '0 : WIDTH'(count + 1'b1);
   assign out_tick   = enable ? wrap : tick;

   // clear wins over counting so a restart is always clean
   always_ff @(posedge clock)
   begin
      if (rst || clear)
         count <= '0;
      else if (tick && enable)
         count <= next_count;
   end
endmodule // twim_prescaler

// >>> tb/tb_timer_watchdog_irq_mask.sv
`timescale 1ns/1ps
// ************************************************************
// bench for the timer, watchdog and interrupt mask block
// ************************************************************
module tb_timer_watchdog_irq_mask
   import twim_pkg::*;
   ;
   localparam int WD = 20;
   logic        clock, rst, hwrite, hsel, tpin, adc, busy, lvd;
   logic [31:0] haddr, hwdata, q, v;
   logic [1:0]  htrans;
   logic [2:0]  hsize, pwm;
   logic [7:0]  p5, p6;
   wire  [31:0] hrdata;
   wire         hrdy, hresp, irq, vec, wake, slp, wdr;
   int          mismatches, checked, n, wdr_cnt;

   // short time-out so the watchdog fires three times per run
   twim_core #(.WDOG_CYCLES(WD)) uut (.clock(clock), .rst(rst), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel),
      .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
      .port5_pins(p5), .port6_pins(p6), .timer_pin(tpin), .pwm_flags(pwm),
      .adc_done_flag(adc), .adc_busy(busy), .low_voltage_flag(lvd),
      .irq_request(irq), .vector_taken(vec), .wake_up(wake), .sleeping(slp),
      .watchdog_reset(wdr));

   // 250 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // time-out pulses counted for the quiet checks
   always @(posedge clock)
      if (wdr === 1'b1)
         wdr_cnt <= wdr_cnt + 1;

   function automatic logic sig(input int k);
      return k == 0 ? irq : k == 1 ? vec : k == 2 ? wake : wdr;
   endfunction

   // exact when lo equals hi, else a window for phase slack
   task automatic chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
      checked++;
      if (lo === hi ? g !== lo : ((^g) === 1'bx || g < lo || g > hi))
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
      end
   endtask

   // one single transfer; hready is sampled at each edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      {haddr, htrans, hwrite} <= {24'h0, a, 2'h2, w};
      @(posedge clock);
      while (hrdy !== 1'b1)
         @(posedge clock);
      {htrans, hwdata} <= {2'h0, d};
      @(posedge clock);
      while (hrdy !== 1'b1)
         @(posedge clock);
      q = hrdata;
   endtask

   // watch at falling edges so a one-cycle pulse is never missed
   task automatic obs(input int k, input int lim, input logic e);
      logic h;
      h = 1'b0;
      n = 0;
      while (n < lim && !(h && e))
      begin
         @(negedge clock);
         h = h | (sig(k) === 1'b1);
         n++;
      end
      @(posedge clock);
      chk({31'h0, h}, {31'h0, e}, {31'h0, e});
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // hang guard, far beyond the 1,200 or so cycles the tests need
   initial
   begin
      #200000;
      mismatches++;
      summarize;
   end

   // main sequence
   initial
   begin
      {rst, haddr, htrans, hwrite, hwdata, hsel, hsize} = {1'b1, 67'h0, 1'b1, 3'h2};
      {p5, p6, tpin, pwm, adc, busy, lvd} = {8'hFF, 15'h0};
      void'($urandom(4));
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      bus(0, TWIM_ADDR_WDOG_CTRL, 32'h0);
      chk(q & 32'hFF, {24'h0, TWIM_WDOG_CTRL_RESET}, {24'h0, TWIM_WDOG_CTRL_RESET});
      bus(0, TWIM_ADDR_IRQ_MASK, 32'h0);
      chk(q & 32'hFF, {24'h0, TWIM_IRQ_MASK_RESET}, {24'h0, TWIM_IRQ_MASK_RESET});
      // watchdog enable kept off so random values cannot fire it
      for (int i = 0; i < 8; i++)
      begin
         v = $urandom & ((i % 2) ? 32'hFF : 32'h7F);
         bus(1, 8'(4 * (i % 2)), v);
         bus(0, 8'(4 * (i % 2)), 32'h0);
         chk(q & 32'hFF, v, v);
      end
      bus(1, TWIM_ADDR_WDOG_CTRL, 32'h0);
      bus(1, TWIM_ADDR_IRQ_MASK, 32'h0);
      bus(1, 8'h1C, 32'hFF);
      bus(0, 8'h1C, 32'h0);
      chk(q, 32'h0, 32'h0);
      // timer rate, undivided then prescaled after a clearing write
      bus(1, TWIM_ADDR_TIMER_CTRL, 32'h0);
      bus(0, TWIM_ADDR_TIMER, 32'h0);
      v = q;
      bus(0, TWIM_ADDR_TIMER, 32'h0);
      chk((q - v) & 32'hFF, 32'h1, 32'h1);
      for (int s = 0; s < 3; s++)
      begin
         bus(1, TWIM_ADDR_TIMER_CTRL, 32'h8 | 32'(s));
         bus(1, TWIM_ADDR_TIMER, 32'h0);
         repeat (126) @(posedge clock);
         bus(0, TWIM_ADDR_TIMER, 32'h0);
         chk(q & 32'hFF, 32'(63 >> (s + 1)), 32'(64 >> (s + 1)));
      end
      // external pin edges, rising then falling; each level held four cycles
      for (int e = 0; e < 2; e++)
      begin
         bus(1, TWIM_ADDR_TIMER_CTRL, 32'h20 | 32'(e << 4));
         bus(1, TWIM_ADDR_TIMER, 32'h0);
         repeat (5)
         begin
            tpin <= ~tpin;
            repeat (4) @(posedge clock);
         end
         repeat (4) @(posedge clock);
         bus(0, TWIM_ADDR_TIMER, 32'h0);
         chk(q & 32'hFF, 32'h3, 32'h3);
      end
      // instruction clock at a quarter of the main clock
      bus(1, TWIM_ADDR_WAKE_CTRL, 32'h4);
      bus(1, TWIM_ADDR_TIMER_CTRL, 32'h0);
      bus(1, TWIM_ADDR_TIMER, 32'h0);
      repeat (126) @(posedge clock);
      bus(0, TWIM_ADDR_TIMER, 32'h0);
      chk(q & 32'hFF, 32'h1F, 32'h20);
      bus(1, TWIM_ADDR_WAKE_CTRL, 32'h0);
      // overflow raises a request only while globally enabled
      bus(1, TWIM_ADDR_TIMER_CTRL, 32'h0);
      bus(1, TWIM_ADDR_IRQ_MASK, 32'h1);
      bus(1, TWIM_ADDR_COMMAND, 32'h4);
      bus(1, TWIM_ADDR_TIMER, 32'hF0);
      obs(0, 6, 1'b0);
      obs(0, 40, 1'b1);
      bus(1, TWIM_ADDR_COMMAND, 32'h8);
      @(posedge clock);
      obs(0, 4, 1'b0);
      bus(1, TWIM_ADDR_COMMAND, 32'h4);
      obs(0, 4, 1'b1);
      // time-out length undivided, 1:2 and 1:4
      for (int s = 0; s < 3; s++)
      begin
         bus(1, TWIM_ADDR_WDOG_CTRL, s == 0 ? 32'h80 : 32'h90 | 32'((s - 1) << 1));
         obs(3, 400, 1'b1);
         chk(32'(n), 32'(WD << s) - 2, 32'((WD << s) + (1 << s) + 3));
         bus(1, TWIM_ADDR_WDOG_CTRL, 32'h0);
      end
      // clearing faster than the time-out keeps it quiet
      v = 32'(wdr_cnt);
      bus(1, TWIM_ADDR_WDOG_CTRL, 32'h80);
      repeat (6)
      begin
         repeat (10) @(posedge clock);
         bus(1, TWIM_ADDR_COMMAND, 32'h1);
      end
      bus(1, TWIM_ADDR_WDOG_CTRL, 32'h0);
      chk(32'(wdr_cnt) - v, 32'h0, 32'h0);
      obs(3, 60, 1'b0);
      // random sources against random mask and low voltage enable
      for (int i = 0; i < 6; i++)
      begin
         v = $urandom;
         {pwm, adc, lvd} <= {v[3:0], v[8]};
         bus(1, TWIM_ADDR_IRQ_MASK, v & 32'hF0);
         bus(1, TWIM_ADDR_WDOG_CTRL, {31'h0, v[9]});
         bus(1, TWIM_ADDR_COMMAND, 32'h10);
         @(posedge clock);
         obs(0, 3, |(v[3:0] & v[7:4]) | (v[8] & v[9]));
      end
      {pwm, adc, lvd} <= 5'h0;
      bus(1, TWIM_ADDR_IRQ_MASK, 32'hC);
      // falling pin edge counts only when the pin is selected
      for (int i = 0; i < 4; i++)
      begin
         bus(1, TWIM_ADDR_WDOG_CTRL, 32'(i % 2) << (6 - i / 2));
         bus(1, TWIM_ADDR_COMMAND, 32'h10);
         p5[2 + i / 2] <= 1'b0;
         repeat (6) @(posedge clock);
         bus(0, TWIM_ADDR_STATUS, 32'h0);
         chk({31'h0, q[10 + i / 2]}, 32'h0, 32'h0);
         p5[2 + i / 2] <= 1'b1;
         obs(0, 8, 1'(i % 2));
      end
      bus(1, TWIM_ADDR_IRQ_MASK, 32'h2);
      bus(1, TWIM_ADDR_COMMAND, 32'h10);
      p6 <= 8'h01;
      obs(1, 12, 1'b1);
      bus(1, TWIM_ADDR_COMMAND, 32'h18);
      @(posedge clock);
      p6 <= 8'h00;
      obs(1, 12, 1'b0);
      // sleep with and without the port wake enable
      for (int i = 0; i < 2; i++)
      begin
         bus(1, TWIM_ADDR_WAKE_CTRL, 32'(1 - i));
         bus(1, TWIM_ADDR_COMMAND, 32'h2);
         bus(0, TWIM_ADDR_TIMER, 32'h0);
         v = q;
         p6 <= ~p6;
         obs(2, 12, 1'(1 - i));
         @(negedge clock);
         chk({31'h0, slp}, 32'(i), 32'(i));
         bus(0, TWIM_ADDR_TIMER, 32'h0);
         if (i == 1)
            chk(q, v, v);
      end
      bus(1, TWIM_ADDR_COMMAND, 32'h20);
      summarize;
   end
endmodule // tb_timer_watchdog_irq_mask

// >>> tb/twim_core_chk.sv
`timescale 1ns/1ps
// ************************************************************
// bus and output checks
// ************************************************************
module twim_core_chk
   import twim_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hsel,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        irq_request,
   input wire logic        vector_taken,
   input wire logic        wake_up,
   input wire logic        sleeping,
   input wire logic        watchdog_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // read address phase accepted by the slave
   wire logic rd_ph = hsel && hready && htrans[1] && !hwrite;

   // zero wait states, never an error response
   chk_ready_const: assert property (hreadyout)
      else $error("hreadyout dropped");
   chk_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   // every output except hreadyout quiet on the first cycle out of reset
   chk_reset_quiet: assert property ($fell(rst) |-> hrdata == 32'h0 && !irq_request
      && !vector_taken && !wake_up && !sleeping && !watchdog_reset)
      else $error("output active after reset");
   // time-out is a single pulse, not a level
   chk_wdog_pulse: assert property (watchdog_reset |=> !watchdog_reset)
      else $error("watchdog reset longer than one cycle");
   // a wake leaves the sleep state at once
   chk_wake_pulse: assert property (wake_up |=> !wake_up && !sleeping)
      else $error("wake pulse without leaving sleep");
   // the port change vector is one of the enabled requests
   chk_vector_irq: assert property (vector_taken |-> irq_request)
      else $error("vector without interrupt request");
   // holes in the map read as zero
   chk_unmapped_zero: assert property (rd_ph && haddr > 32'h18 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   // read data stands until the next read
   chk_rdata_hold: assert property (!rd_ph |=> $stable(hrdata))
      else $error("hrdata moved without a read");
endmodule // twim_core_chk

bind twim_core twim_core_chk chk_i (.clock(clock), .rst(rst), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsel(hsel), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .irq_request(irq_request),
   .vector_taken(vector_taken), .wake_up(wake_up), .sleeping(sleeping),
   .watchdog_reset(watchdog_reset));
